// ===== verilog/ctr_map.svh
// Purpose: constants of the channel telemetry readout (command codes, fields, resets)
// Assumes: included by bare name from the readout design files
// Notes: all result registers are read-only; two data bytes, low byte first
// Function
// - channel 3 current: code 38h, read-only
// - channel 4 current: code 3Ch, read-only
// - channel 1 voltage: code 32h, read-only
// - channel 2 voltage: code 36h, read-only
// - low byte sent first, high second
// - 14-bit result, top bits zero, resets zero
// - current equals code times 70.19 uA
// - full scale 1.15 A, may saturate lower
// - channel off mode reads zero
// - semiauto off, invalid detection reads zero
// - manual mode keeps last value once enabled
// - host sums two channels for 4-pair
// - classification current held after class measurement
// - class value replaced by powered reading, disable
// - only final classification pulse is stored
// - classes 5-8 report class 0-3 levels
// - channel 1 current: code 30h, read-only
// - channel 2 current: code 34h, read-only
`ifndef CTR_MAP_SVH
`define CTR_MAP_SVH

// command codes of the result registers
`define CTR_CMD_CH1_CUR 8'h30
`define CTR_CMD_CH1_VOLT 8'h32
`define CTR_CMD_CH2_CUR 8'h34
`define CTR_CMD_CH2_VOLT 8'h36
`define CTR_CMD_CH3_CUR 8'h38
`define CTR_CMD_CH4_CUR 8'h3C

// field layout of a two-byte result
`define CTR_RES_W 14
`define CTR_RES_MSB 13
`define CTR_LOW_BYTE_LSB 0
`define CTR_HIGH_BYTE_LSB 8
`define CTR_RES_RESET 14'h0000
`define CTR_WORD_RESET 16'h0000
`define CTR_FILL_BYTE 8'h00
`define CTR_FULL_SCALE_CODE 14'h3FFF

// current scaling: step in nA, nominal full scale in uA with a 255 mohm sense
`define CTR_ISTEP_NA 70190
`define CTR_FULL_SCALE_UA 1150000
`define CTR_MIN_FULL_SCALE_UA 1050000
`define CTR_SENSE_MOHM 255

`endif

// ===== verilog/ctr_pkg.sv
// Purpose: types shared by the channel telemetry readout
// Assumes: nothing beyond the constants header
// Notes: no codes are given to the enums
package ctr_pkg;

    // operating mode of one channel as set by the controller
    typedef enum logic [1:0] {
        CTR_MODE_OFF,
        CTR_MODE_MANUAL,
        CTR_MODE_SEMIAUTO,
        CTR_MODE_AUTO
    } ctr_mode_e;

    // byte sequencer of a two-byte read
    typedef enum logic [1:0] {
        CTR_RD_IDLE,
        CTR_RD_LOW,
        CTR_RD_HIGH
    } ctr_rd_state_e;

endpackage

// ===== verilog/ctr_chan_current.sv
// Purpose: holds one channel's current result and masks it for reading
// Assumes: strobes and data come from the channel's converter on clk_sys_i
// Notes: result_o is combinational from held state and the mode inputs
`timescale 1ns/10ps
`include "ctr_map.svh"

module ctr_chan_current #(
    parameter int W = `CTR_RES_W
) (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire ctr_pkg::ctr_mode_e mode_i,
    input wire logic powered_i,
    input wire logic detcls_en_i,
    input wire logic det_invalid_i,
    input wire logic port_disable_i,
    input wire logic meas_valid_i,
    input wire logic class_valid_i,
    input wire logic class_last_i,
    input wire logic [W-1:0] meas_i,
    output logic [W-1:0] result_o
);

    logic [W-1:0] value; // last stored measurement
    logic [W-1:0] next_value;
    logic class_held; // value is a classification current
    logic next_class_held;
    logic ever_en; // detect/class was enabled at least once
    logic next_ever_en;
    logic retain; // manual mode keeps the value over a disable
    logic force_zero; // read mask

    ////////////////////////////////////////////////////////////////////////
    // next stored value
    always_comb
    begin
        next_value = value;
        next_class_held = class_held;
        next_ever_en = ever_en | detcls_en_i;
        retain = (mode_i == ctr_pkg::CTR_MODE_MANUAL) && ever_en;
        if (class_valid_i && class_last_i)
        begin
            // only the final pulse lands here, so a 5..8 load shows 0..3
            next_value = meas_i;
            next_class_held = 1'b1;
        end
        else if (meas_valid_i && powered_i)
        begin
            // raw code kept as is: current = code * step, saturates at all ones
            next_value = meas_i;
            next_class_held = 1'b0;
        end
        else if (port_disable_i)
        begin
            next_class_held = 1'b0;
            if (!retain)
            begin
                next_value = `CTR_RES_RESET;
            end
        end
    end

    // register the held state
    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            value <= `CTR_RES_RESET;
            class_held <= 1'b0;
            ever_en <= 1'b0;
        end
        else
        begin
            value <= next_value;
            class_held <= next_class_held;
            ever_en <= next_ever_en;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read mask: off channels answer zero without losing the held value
    always_comb
    begin
        force_zero = 1'b0;
        if (mode_i == ctr_pkg::CTR_MODE_OFF)
        begin
            force_zero = 1'b1;
        end
        else if (mode_i == ctr_pkg::CTR_MODE_SEMIAUTO && !powered_i)
        begin
            force_zero = !detcls_en_i || det_invalid_i;
        end
        result_o = force_zero ? `CTR_RES_RESET : value;
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!resetn_i);

    a_off_reads_zero: assert property (mode_i == ctr_pkg::CTR_MODE_OFF |-> result_o == '0)
        else $error("off channel does not read zero");
    a_semi_noen_zero: assert property (
        mode_i == ctr_pkg::CTR_MODE_SEMIAUTO && !powered_i && !detcls_en_i |-> result_o == '0)
        else $error("semiauto disabled channel does not read zero");
    a_semi_bad_zero: assert property (
        mode_i == ctr_pkg::CTR_MODE_SEMIAUTO && !powered_i && det_invalid_i |-> result_o == '0)
        else $error("semiauto invalid detection does not read zero");
    a_class_last_kept: assert property (
        class_valid_i && class_last_i |=> value == $past(meas_i) && class_held)
        else $error("final class current not stored");
    a_class_early_drop: assert property (
        class_valid_i && !class_last_i && !meas_valid_i && !port_disable_i |=> $stable(value))
        else $error("early class pulse changed the result");
    a_class_replaced: assert property (
        class_held && meas_valid_i && powered_i && !class_valid_i ##1 !class_valid_i
        |-> !class_held)
        else $error("class current not replaced by powered reading");
    a_manual_retain: assert property (
        mode_i == ctr_pkg::CTR_MODE_MANUAL && ever_en && port_disable_i
        && !class_valid_i && !meas_valid_i |=> $stable(value))
        else $error("manual mode lost the last value");
    c_class_then_power: cover property (class_held ##[1:20] (!class_held && value != '0));
    c_manual_retain: cover property (retain && port_disable_i && value != '0);

endmodule

// ===== verilog/ctr_readout.sv
// Purpose: read-only telemetry result registers behind the serial command port
// Assumes: command and byte strobes come from the serial engine on clk_sys_i
// Notes: a read start snapshots the whole word; writes are dropped
`timescale 1ns/10ps
`include "ctr_map.svh"

module ctr_readout #(
    parameter int RES_W = `CTR_RES_W
) (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    // command port from the serial engine
    input wire logic cmd_start_i,
    input wire logic cmd_read_i,
    input wire logic [7:0] cmd_code_i,
    input wire logic byte_req_i,
    // per-channel controller state
    input wire ctr_pkg::ctr_mode_e chan_mode_i [4],
    input wire logic [3:0] chan_powered_i,
    input wire logic [3:0] chan_detcls_en_i,
    input wire logic [3:0] chan_det_invalid_i,
    input wire logic [3:0] chan_disable_i,
    // converter results
    input wire logic [3:0] cur_valid_i,
    input wire logic [3:0] class_valid_i,
    input wire logic [3:0] class_last_i,
    input wire logic [RES_W-1:0] cur_meas_i [4],
    input wire logic [1:0] volt_valid_i,
    input wire logic [RES_W-1:0] volt_meas_i [2],
    // answer to the serial engine
    output logic [7:0] tx_byte_o,
    output logic tx_valid_o,
    output logic cmd_hit_o,
    output logic wr_ignored_o
);

    localparam int NCH = 4; // fixed by the command map

    ////////////////////////////////////////////////////////////////////////
    // current results, one holder per channel
    logic [RES_W-1:0] cur_result [NCH]; // chan1..chan4 current results

    // each channel reports alone; a four-pair port total is summed by the host
    genvar gi;
    generate
        for (gi = 0; gi < NCH; gi++)
        begin : g_chan
            ctr_chan_current #(
                .W(RES_W)
            ) u_cur (
                .clk_sys_i(clk_sys_i),
                .resetn_i(resetn_i),
                .mode_i(chan_mode_i[gi]),
                .powered_i(chan_powered_i[gi]),
                .detcls_en_i(chan_detcls_en_i[gi]),
                .det_invalid_i(chan_det_invalid_i[gi]),
                .port_disable_i(chan_disable_i[gi]),
                .meas_valid_i(cur_valid_i[gi]),
                .class_valid_i(class_valid_i[gi]),
                .class_last_i(class_last_i[gi]),
                .meas_i(cur_meas_i[gi]),
                .result_o(cur_result[gi])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // voltage results of channels 1 and 2
    logic [RES_W-1:0] chan1_voltage_result;
    logic [RES_W-1:0] chan2_voltage_result;
    logic [RES_W-1:0] next_chan1_voltage_result;
    logic [RES_W-1:0] next_chan2_voltage_result;
    logic [RES_W-1:0] volt_read [2]; // masked for reading

    // the held voltage follows the converter; an off channel reads zero
    // masking after the register keeps the last voltage across an off spell
    always_comb
    begin
        next_chan1_voltage_result = chan1_voltage_result;
        next_chan2_voltage_result = chan2_voltage_result;
        if (volt_valid_i[0])
        begin
            next_chan1_voltage_result = volt_meas_i[0];
        end
        if (volt_valid_i[1])
        begin
            next_chan2_voltage_result = volt_meas_i[1];
        end
        volt_read[0] = chan1_voltage_result;
        volt_read[1] = chan2_voltage_result;
        if (chan_mode_i[0] == ctr_pkg::CTR_MODE_OFF)
        begin
            volt_read[0] = `CTR_RES_RESET;
        end
        if (chan_mode_i[1] == ctr_pkg::CTR_MODE_OFF)
        begin
            volt_read[1] = `CTR_RES_RESET;
        end
    end

    // register the voltages
    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            chan1_voltage_result <= `CTR_RES_RESET;
            chan2_voltage_result <= `CTR_RES_RESET;
        end
        else
        begin
            chan1_voltage_result <= next_chan1_voltage_result;
            chan2_voltage_result <= next_chan2_voltage_result;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // command decode
    logic [RES_W-1:0] sel_data; // addressed result
    logic sel_hit; // code is one of ours

    // only these codes are mapped; anything else answers fill bytes
    // a miss still answers two bytes, so the engine never stalls
    always_comb
    begin
        sel_data = `CTR_RES_RESET;
        sel_hit = 1'b1;
        case (cmd_code_i)
            `CTR_CMD_CH1_CUR:
            begin
                sel_data = cur_result[0];
            end
            `CTR_CMD_CH2_CUR:
            begin
                sel_data = cur_result[1];
            end
            `CTR_CMD_CH3_CUR:
            begin
                sel_data = cur_result[2];
            end
            `CTR_CMD_CH4_CUR:
            begin
                sel_data = cur_result[3];
            end
            `CTR_CMD_CH1_VOLT:
            begin
                sel_data = volt_read[0];
            end
            `CTR_CMD_CH2_VOLT:
            begin
                sel_data = volt_read[1];
            end
            default:
            begin
                sel_hit = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // byte sequencer
    ctr_pkg::ctr_rd_state_e state;
    ctr_pkg::ctr_rd_state_e next_state;
    logic [15:0] shadow; // word frozen at the read start
    logic [15:0] next_shadow;
    logic [7:0] next_tx_byte;
    logic next_tx_valid;
    logic next_cmd_hit;
    logic next_wr_ignored;
    logic chan1_voltage_top_bit; // sign of range use, for visibility only in checks

    assign chan1_voltage_top_bit = chan1_voltage_result[`CTR_RES_MSB];

    // a new read command always restarts the sequence, even mid-transfer; a write start ends it in idle
    // tx_byte_o holds between requests, so the engine may sample late
    always_comb
    begin
        next_state = state;
        next_shadow = shadow;
        next_tx_byte = tx_byte_o;
        next_tx_valid = 1'b0;
        next_cmd_hit = cmd_hit_o;
        next_wr_ignored = 1'b0;
        if (cmd_start_i && cmd_read_i)
        begin
            // both bytes from one conversion, upper two bits zero
            next_shadow = {2'b00, sel_data};
            next_cmd_hit = sel_hit;
            next_state = ctr_pkg::CTR_RD_LOW;
        end
        else if (cmd_start_i)
        begin
            // stored values stay untouched; the engine sees the pulse
            next_wr_ignored = 1'b1;
            next_cmd_hit = 1'b0;
            next_state = ctr_pkg::CTR_RD_IDLE;
        end
        else if (byte_req_i)
        begin
            next_tx_valid = 1'b1;
            case (state)
                ctr_pkg::CTR_RD_LOW:
                begin
                    next_tx_byte = shadow[`CTR_LOW_BYTE_LSB +: 8];
                    next_state = ctr_pkg::CTR_RD_HIGH;
                end
                ctr_pkg::CTR_RD_HIGH:
                begin
                    next_tx_byte = shadow[`CTR_HIGH_BYTE_LSB +: 8];
                    next_state = ctr_pkg::CTR_RD_IDLE;
                end
                default:
                begin
                    // reads past the second byte get fill
                    next_tx_byte = `CTR_FILL_BYTE;
                end
            endcase
        end
    end

    // register the sequencer and all outputs
    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            state <= ctr_pkg::CTR_RD_IDLE;
            shadow <= `CTR_WORD_RESET;
            tx_byte_o <= `CTR_FILL_BYTE;
            tx_valid_o <= 1'b0;
            cmd_hit_o <= 1'b0;
            wr_ignored_o <= 1'b0;
        end
        else
        begin
            state <= next_state;
            shadow <= next_shadow;
            tx_byte_o <= next_tx_byte;
            tx_valid_o <= next_tx_valid;
            cmd_hit_o <= next_cmd_hit;
            wr_ignored_o <= next_wr_ignored;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!resetn_i);

    a_ch1_cur_read: assert property (
        cmd_start_i && cmd_read_i && cmd_code_i == `CTR_CMD_CH1_CUR
        |=> cmd_hit_o && shadow[13:0] == $past(cur_result[0]))
        else $error("channel 1 current read wrong");
    a_ch2_cur_read: assert property (
        cmd_start_i && cmd_read_i && cmd_code_i == `CTR_CMD_CH2_CUR
        |=> cmd_hit_o && shadow[13:0] == $past(cur_result[1]))
        else $error("channel 2 current read wrong");
    a_ch3_cur_read: assert property (
        cmd_start_i && cmd_read_i && cmd_code_i == `CTR_CMD_CH3_CUR
        |=> cmd_hit_o && shadow[13:0] == $past(cur_result[2]))
        else $error("channel 3 current read wrong");
    a_ch4_cur_read: assert property (
        cmd_start_i && cmd_read_i && cmd_code_i == `CTR_CMD_CH4_CUR
        |=> cmd_hit_o && shadow[13:0] == $past(cur_result[3]))
        else $error("channel 4 current read wrong");
    a_v1_read: assert property (
        cmd_start_i && cmd_read_i && cmd_code_i == `CTR_CMD_CH1_VOLT
        |=> cmd_hit_o && shadow[13:0] == $past(volt_read[0]))
        else $error("channel 1 voltage read wrong");
    a_v2_read: assert property (
        cmd_start_i && cmd_read_i && cmd_code_i == `CTR_CMD_CH2_VOLT
        |=> cmd_hit_o && shadow[13:0] == $past(volt_read[1]))
        else $error("channel 2 voltage read wrong");
    a_low_byte_first: assert property (
        cmd_start_i && cmd_read_i ##1 (byte_req_i && !cmd_start_i)
        |=> tx_valid_o && tx_byte_o == $past(shadow[7:0]))
        else $error("low byte not sent first");
    a_high_top_zero: assert property (
        state == ctr_pkg::CTR_RD_HIGH && byte_req_i && !cmd_start_i
        |=> tx_valid_o && tx_byte_o[7:6] == 2'b00)
        else $error("unused high bits not zero");
    a_word_frozen: assert property (!cmd_start_i |=> $stable(shadow))
        else $error("read word changed during transfer");
    a_write_ignored: assert property (
        cmd_start_i && !cmd_read_i |=> wr_ignored_o && !cmd_hit_o && state == ctr_pkg::CTR_RD_IDLE)
        else $error("write to result register not ignored");
    // byte handshake: one answer per accepted request, fill past the word
    a_valid_follows_req: assert property (
        byte_req_i && !cmd_start_i |=> tx_valid_o)
        else $error("byte request not answered");
    a_no_stray_valid: assert property (
        !(byte_req_i && !cmd_start_i) |=> !tx_valid_o)
        else $error("byte valid without request");
    a_fill_past_end: assert property (
        state == ctr_pkg::CTR_RD_IDLE && byte_req_i && !cmd_start_i |=> tx_byte_o == `CTR_FILL_BYTE)
        else $error("byte past the word is not fill");
    // covers: a plain two-byte read, a dropped write, a high voltage code
    c_two_byte_read: cover property (
        cmd_start_i && cmd_read_i && sel_hit ##[1:8] byte_req_i ##[1:8] byte_req_i);
    c_write_drop: cover property (wr_ignored_o);
    c_v1_top_bit: cover property (chan1_voltage_top_bit);

endmodule

// ===== test/ctr_host_model.sv
// Purpose: serial engine model that issues command starts and byte requests
// Assumes: same clock as the readout; every change lands 10 ns after a rising edge
// Notes: released code and read lines carry the inverse of the last value
`timescale 1ns/10ps

module ctr_host_model (
    input wire logic clk_sys_i,
    input wire logic [7:0] tx_byte_i,
    input wire logic tx_valid_i,
    input wire logic cmd_hit_i,
    input wire logic wr_ignored_i,
    output logic cmd_start_o,
    output logic cmd_read_o,
    output logic [7:0] cmd_code_o,
    output logic byte_req_o
);
    // idle port at time zero
    initial
    begin
        cmd_start_o = 1'b0;
        cmd_read_o = 1'b0;
        cmd_code_o = 8'h00;
        byte_req_o = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // start pulse; the qualifiers are scrambled once the start has been taken
    task automatic start(input logic rd, input logic [7:0] code);
        @(posedge clk_sys_i);
        #10;
        cmd_start_o = 1'b1;
        cmd_read_o = rd;
        cmd_code_o = code;
        @(posedge clk_sys_i);
        #10;
        cmd_start_o = 1'b0;
        cmd_read_o = ~rd;
        cmd_code_o = ~code;
    endtask

    // two-byte read, back-to-back byte requests, bytes taken as they come
    task automatic read_word(input logic [7:0] code, output logic [7:0] lo,
                             output logic [7:0] hi, output logic hit,
                             output logic [1:0] vld);
        start(1'b1, code);
        hit = cmd_hit_i;
        byte_req_o = 1'b1;
        @(posedge clk_sys_i);
        #10;
        vld[0] = tx_valid_i;
        lo = tx_byte_i;
        @(posedge clk_sys_i);
        #10;
        vld[1] = tx_valid_i;
        hi = tx_byte_i;
        byte_req_o = 1'b0;
    endtask

    // write start; only used where a refusal is expected
    task automatic write_cmd(input logic [7:0] code, output logic [1:0] ign,
                             output logic hit);
        start(1'b0, code);
        ign[0] = wr_ignored_i;
        hit = cmd_hit_i;
        @(posedge clk_sys_i);
        #10;
        ign[1] = wr_ignored_i;
    endtask
endmodule

// ===== test/test_channel_telemetry_readout.sv
// Purpose: self-checking bench of the telemetry result registers
// Assumes: host model drives the command port, bench drives channel state
// Notes: each scenario task judges its own reads
`timescale 1ns/10ps
`include "ctr_map.svh"

module test_channel_telemetry_readout;
    logic clk_sys_i = 1'b0;
    logic resetn_i = 1'b0;
    logic cmd_start, cmd_read, byte_req;
    logic [7:0] cmd_code, tx_byte;
    logic tx_valid, cmd_hit, wr_ignored;
    ctr_pkg::ctr_mode_e mode [4];
    logic [3:0] powered = 4'h0, detcls = 4'h0, detinv = 4'h0, dis = 4'h0;
    logic [3:0] cur_v = 4'h0, cls_v = 4'h0, cls_l = 4'h0;
    logic [1:0] volt_v = 2'h0;
    logic [13:0] cur_m [4];
    logic [13:0] volt_m [2];
    int n_fail = 0;
    int cmp_count = 0;

    // 10 MHz system clock
    always #50 clk_sys_i = ~clk_sys_i;

    ctr_readout dut (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
        .cmd_start_i(cmd_start), .cmd_read_i(cmd_read), .cmd_code_i(cmd_code),
        .byte_req_i(byte_req), .chan_mode_i(mode), .chan_powered_i(powered),
        .chan_detcls_en_i(detcls), .chan_det_invalid_i(detinv),
        .chan_disable_i(dis), .cur_valid_i(cur_v), .class_valid_i(cls_v),
        .class_last_i(cls_l), .cur_meas_i(cur_m), .volt_valid_i(volt_v),
        .volt_meas_i(volt_m), .tx_byte_o(tx_byte), .tx_valid_o(tx_valid),
        .cmd_hit_o(cmd_hit), .wr_ignored_o(wr_ignored));

    ctr_host_model host (.clk_sys_i(clk_sys_i), .tx_byte_i(tx_byte),
        .tx_valid_i(tx_valid), .cmd_hit_i(cmd_hit), .wr_ignored_i(wr_ignored),
        .cmd_start_o(cmd_start), .cmd_read_o(cmd_read), .cmd_code_o(cmd_code),
        .byte_req_o(byte_req));

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic stop_test();
        $display("comparisons %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // one converter event: 0 current, 1 class pulse, 2 disable, 3 voltage
    task automatic pulse(input int kind, input int ch, input logic [13:0] v,
                         input logic last);
        @(posedge clk_sys_i);
        #10;
        if (kind == 3)
        begin
            volt_m[ch] = v;
            volt_v[ch] = 1'b1;
        end
        else
            cur_m[ch] = v;
        cur_v[ch] = (kind == 0);
        cls_v[ch] = (kind == 1);
        cls_l[ch] = last;
        dis[ch] = (kind == 2);
        @(posedge clk_sys_i);
        #10;
        {cur_v[ch], cls_v[ch], dis[ch]} = 3'b000;
        cls_l[ch] = ~last;
        if (kind == 3)
        begin
            volt_v[ch] = 1'b0;
            volt_m[ch] = ~v;
        end
        else
            cur_m[ch] = ~v;
    endtask

    // read one register; word expected as {00, result}
    task automatic rd_chk(input logic [7:0] code, input logic [15:0] exp,
                          input logic hit_exp);
        logic [7:0] lo, hi;
        logic hit;
        logic [1:0] vld;
        host.read_word(code, lo, hi, hit, vld);
        check({15'h0000, hit}, {15'h0000, hit_exp});
        check({14'h0000, vld}, 16'h0003);
        check({8'h00, lo}, {8'h00, exp[7:0]});
        check({8'h00, hi}, {8'h00, exp[15:8]});
    endtask

    ////////////////////////////////////////////////////////////////////////
    logic [7:0] codes [6] = '{`CTR_CMD_CH1_CUR, `CTR_CMD_CH2_CUR, `CTR_CMD_CH3_CUR,
                              `CTR_CMD_CH4_CUR, `CTR_CMD_CH1_VOLT, `CTR_CMD_CH2_VOLT};
    logic [13:0] vals [6] = '{14'h1234, 14'h0ABC, 14'h3FFF, 14'h2001, 14'h2357, 14'h2468};

    // every result is zero after reset; an unmapped code misses
    task automatic t_reset();
        for (int i = 0; i < 6; i++)
            rd_chk(codes[i], `CTR_WORD_RESET, 1'b1);
        rd_chk(8'h31, 16'h0000, 1'b0);
        $display("test reset done");
    endtask

    // each code returns its own channel, low byte first, top bits zero
    task automatic t_order();
        for (int i = 0; i < 4; i++)
            mode[i] = ctr_pkg::CTR_MODE_MANUAL;
        powered = 4'hF;
        for (int i = 0; i < 6; i++)
            pulse(i < 4 ? 0 : 3, i < 4 ? i : i - 4, vals[i], 1'b0);
        for (int i = 0; i < 6; i++)
            rd_chk(codes[i], {2'b00, vals[i]}, 1'b1);
        $display("test order done");
    endtask

    // a write is refused and leaves the result alone
    task automatic t_write();
        logic [1:0] ign;
        logic hit;
        host.write_cmd(`CTR_CMD_CH3_CUR, ign, hit);
        check({14'h0000, ign}, 16'h0001);
        check({15'h0000, hit}, 16'h0000);
        rd_chk(`CTR_CMD_CH3_CUR, 16'h3FFF, 1'b1);
        $display("test write done");
    endtask

    // a conversion landing mid-read must not split the word
    task automatic t_snap();
        logic [7:0] lo1, hi1, lo2, hi2;
        logic h;
        logic [1:0] v;
        fork
            rd_chk(`CTR_CMD_CH3_CUR, 16'h3FFF, 1'b1);
            begin
                @(posedge clk_sys_i);
                pulse(0, 2, 14'h2AAA, 1'b0);
            end
        join
        rd_chk(`CTR_CMD_CH3_CUR, 16'h2AAA, 1'b1);
        // host side: four-pair total is the sum of the two channels
        host.read_word(`CTR_CMD_CH1_CUR, lo1, hi1, h, v);
        host.read_word(`CTR_CMD_CH2_CUR, lo2, hi2, h, v);
        check({hi1, lo1} + {hi2, lo2}, 16'h1CF0);
        $display("test snapshot done");
    endtask

    // zero masks of off and semi-automatic channels
    task automatic t_mask();
        mode[0] = ctr_pkg::CTR_MODE_OFF;
        rd_chk(`CTR_CMD_CH1_CUR, 16'h0000, 1'b1);
        rd_chk(`CTR_CMD_CH1_VOLT, 16'h0000, 1'b1);
        mode[0] = ctr_pkg::CTR_MODE_MANUAL;
        rd_chk(`CTR_CMD_CH1_CUR, 16'h1234, 1'b1);
        mode[1] = ctr_pkg::CTR_MODE_SEMIAUTO;
        powered[1] = 1'b0;
        rd_chk(`CTR_CMD_CH2_CUR, 16'h0000, 1'b1);
        {detcls[1], detinv[1]} = 2'b11;
        rd_chk(`CTR_CMD_CH2_CUR, 16'h0000, 1'b1);
        detinv[1] = 1'b0;
        rd_chk(`CTR_CMD_CH2_CUR, 16'h0ABC, 1'b1);
        $display("test mask done");
    endtask

    // classification current: last pulse kept, then replaced or cleared
    task automatic t_class();
        mode[2] = ctr_pkg::CTR_MODE_AUTO;
        powered[2] = 1'b0;
        pulse(1, 2, 14'h0111, 1'b0);
        rd_chk(`CTR_CMD_CH3_CUR, 16'h2AAA, 1'b1);
        pulse(1, 2, 14'h0222, 1'b1);
        rd_chk(`CTR_CMD_CH3_CUR, 16'h0222, 1'b1);
        powered[2] = 1'b1;
        pulse(0, 2, 14'h0333, 1'b0);
        rd_chk(`CTR_CMD_CH3_CUR, 16'h0333, 1'b1);
        powered[2] = 1'b0;
        pulse(1, 2, 14'h0444, 1'b1);
        pulse(2, 2, 14'h0000, 1'b0);
        rd_chk(`CTR_CMD_CH3_CUR, 16'h0000, 1'b1);
        detcls[3] = 1'b1;
        @(posedge clk_sys_i);
        #10;
        detcls[3] = 1'b0;
        pulse(2, 3, 14'h0000, 1'b0);
        rd_chk(`CTR_CMD_CH4_CUR, 16'h2001, 1'b1);
        $display("test class done");
    endtask

    ////////////////////////////////////////////////////////////////////////
    // watchdog cuts a hang short
    initial
    begin
        repeat (20000) @(posedge clk_sys_i);
        n_fail++;
        stop_test();
    end

    // main sequence
    initial
    begin
        for (int i = 0; i < 4; i++)
        begin
            mode[i] = ctr_pkg::CTR_MODE_OFF;
            cur_m[i] = 14'h0000;
        end
        volt_m[0] = 14'h0000;
        volt_m[1] = 14'h0000;
        repeat (5) @(posedge clk_sys_i);
        #10;
        resetn_i = 1'b1;
        t_reset();
        t_order();
        t_write();
        t_snap();
        t_mask();
        t_class();
        stop_test();
    end
endmodule
